/* File: hdl/ilod_addr_gen.sv */
// Purpose: Effective data-memory address for one file-register operand
// Assumes: Combinational, same clock domain as the core
// Notes:   Pointer sum wraps inside the address space
`timescale 1ns/100ps
`default_nettype none
module ilod_addr_gen (
  // Mode and operand
  input  wire logic                        ext_en_i,
  input  wire logic                        access_i,
  input  wire logic [ilod_pkg::DATA_W-1:0] offset_i,
  // Pointer and bank
  input  wire logic [ilod_pkg::ADDR_W-1:0] idx_ptr_i,
  input  wire logic [ilod_pkg::BANK_W-1:0] bank_i,
  // Result
  output logic      [ilod_pkg::ADDR_W-1:0] eff_addr_o,
  output logic                             indexed_o
);

  logic                        low_range;
  logic [ilod_pkg::ADDR_W-1:0] idx_sum;
  logic [ilod_pkg::ADDR_W-1:0] access_addr;
  logic [ilod_pkg::ADDR_W-1:0] literal_addr;

  assign low_range = (offset_i <= ilod_pkg::ACCESS_OFFSET_MAX);
  // Only a low-range access-bank operand is redirected
  assign indexed_o = ext_en_i & ~access_i & low_range; // RULE1 RULE11 RULE13
  // Carry out of the top address bit is dropped
  assign idx_sum = idx_ptr_i + {{(ilod_pkg::ADDR_W-ilod_pkg::DATA_W){1'b0}}, offset_i}; // RULE14
  assign access_addr = low_range ? {ilod_pkg::ACCESS_LOW_BANK, offset_i}
                                 : {ilod_pkg::ACCESS_HIGH_BANK, offset_i}; // RULE13
  assign literal_addr = access_i ? {bank_i, offset_i} : access_addr; // RULE12
  assign eff_addr_o = indexed_o ? idx_sum : literal_addr; // RULE1

endmodule // ilod_addr_gen
`default_nettype wire

/* File: hdl/ilod_alu.sv */
// Purpose: Result and status flags for add, bit-set and set-all
// Assumes: Combinational, operands stable through the process phase
// Notes:   Flag write enable is high only for the add
`timescale 1ns/100ps
`default_nettype none
module ilod_alu (
  // Operation
  input  wire ilod_pkg::ilod_op_t            op_i,
  input  wire logic [ilod_pkg::BIT_W-1:0]    bit_sel_i,
  // Operands
  input  wire logic [ilod_pkg::DATA_W-1:0]   accum_i,
  input  wire logic [ilod_pkg::DATA_W-1:0]   opnd_i,
  // Result
  output logic      [ilod_pkg::DATA_W-1:0]   result_o,
  output logic      [ilod_pkg::STATUS_W-1:0] flags_o,
  output logic                               flags_wr_o
);

  logic [ilod_pkg::DATA_W:0]   sum;
  logic [ilod_pkg::NIBBLE_W:0] nib_sum;
  logic [ilod_pkg::DATA_W-1:0] bit_mask;

  assign sum     = {1'b0, accum_i} + {1'b0, opnd_i}; // RULE2
  assign nib_sum = {1'b0, accum_i[ilod_pkg::NIBBLE_W-1:0]}
                 + {1'b0, opnd_i[ilod_pkg::NIBBLE_W-1:0]};

  genvar gi;
  generate
    for (gi = 0; gi < ilod_pkg::DATA_W; gi++) begin : g_mask
      assign bit_mask[gi] = (bit_sel_i == ilod_pkg::BIT_W'(gi)); // RULE6
    end
  endgenerate

  assign result_o = (op_i == ilod_pkg::ILOD_OP_ADD)    ? sum[ilod_pkg::DATA_W-1:0] :
                    (op_i == ilod_pkg::ILOD_OP_BSET)   ? (opnd_i | bit_mask) : // RULE6
                    (op_i == ilod_pkg::ILOD_OP_SETALL) ? ilod_pkg::SET_ALL_VALUE : // RULE8
                    opnd_i;

  assign flags_o[ilod_pkg::FLAG_C]  = sum[ilod_pkg::DATA_W]; // RULE4
  assign flags_o[ilod_pkg::FLAG_DC] = nib_sum[ilod_pkg::NIBBLE_W]; // RULE4
  assign flags_o[ilod_pkg::FLAG_Z]  = (sum[ilod_pkg::DATA_W-1:0] == 8'h00); // RULE4
  assign flags_o[ilod_pkg::FLAG_OV] = (accum_i[ilod_pkg::DATA_W-1] == opnd_i[ilod_pkg::DATA_W-1])
    & (sum[ilod_pkg::DATA_W-1] != accum_i[ilod_pkg::DATA_W-1]); // RULE4
  assign flags_o[ilod_pkg::FLAG_N]  = sum[ilod_pkg::DATA_W-1]; // RULE4
  // Bit-set and set-all leave every flag alone
  assign flags_wr_o = (op_i == ilod_pkg::ILOD_OP_ADD); // RULE4 RULE6 RULE8

endmodule // ilod_alu
`default_nettype wire

/* File: hdl/ilod_pkg.sv */
// Purpose: Shared constants and types for the indexed literal offset decoder
// Assumes: 8-bit data path, 12-bit data-memory address, 16-bit instruction word
// Notes:   Opcode patterns compare against the upper instruction bits only
package ilod_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int DATA_W   = 8;
  localparam int ADDR_W   = 12;
  localparam int BANK_W   = 4;
  localparam int INSTR_W  = 16;
  localparam int BIT_W    = 3;
  localparam int NIBBLE_W = 4;
  localparam int STATUS_W = 5;

  // ************************************************************
  // Addressing
  // ************************************************************
  localparam logic [DATA_W-1:0] ACCESS_OFFSET_MAX = 8'h5F;
  localparam logic [BANK_W-1:0] ACCESS_LOW_BANK   = 4'h0;
  localparam logic [BANK_W-1:0] ACCESS_HIGH_BANK  = 4'hF;

  // ************************************************************
  // Instruction fields
  // ************************************************************
  localparam int OFFSET_MSB = 7;
  localparam int ACCESS_BIT = 8;
  localparam int DEST_BIT   = 9;
  localparam int BITNUM_LSB = 9;
  localparam int BITNUM_MSB = 11;

  localparam logic [5:0] ADD_OPCODE    = 6'h09;
  localparam logic [3:0] BSET_OPCODE   = 4'h8;
  localparam logic [6:0] SETALL_OPCODE = 7'h34;

  localparam logic DEST_ACCUM = 1'b0;
  localparam logic DEST_FILE  = 1'b1;

  localparam logic [DATA_W-1:0] SET_ALL_VALUE = 8'hFF;

  // ************************************************************
  // Status flags and reset values
  // ************************************************************
  localparam int FLAG_C  = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z  = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N  = 4;

  localparam logic [STATUS_W-1:0] STATUS_RST = 5'h00;
  localparam logic [DATA_W-1:0]   ACCUM_RST  = 8'h00;
  localparam logic [ADDR_W-1:0]   ADDR_RST   = 12'h000;
  localparam logic [INSTR_W-1:0]  INSTR_RST  = 16'h0000;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ILOD_Q1 = 2'b00,
    ILOD_Q2 = 2'b01,
    ILOD_Q3 = 2'b10,
    ILOD_Q4 = 2'b11
  } ilod_phase_t;

  typedef enum logic [1:0] {
    ILOD_OP_NONE   = 2'b00,
    ILOD_OP_ADD    = 2'b01,
    ILOD_OP_BSET   = 2'b10,
    ILOD_OP_SETALL = 2'b11
  } ilod_op_t;

endpackage

/* File: hdl/ilod_top.sv */
// Purpose: Decode and execute of add, bit-set and set-all with indexed literal offset
// Assumes: All inputs come from logic on ref_clk_i; memory read data returns one cycle
//          after the read strobe
// Notes:   One quadrature phase per clock, four clocks per instruction cycle
//
// Operation
// RULE1 - Low access operands offset the index pointer
// RULE2 - Add accumulator to byte at pointer plus offset
// RULE3 - Destination bit: 0 accumulator, 1 memory
// RULE4 - Add updates N, OV, C, DC, Z
// RULE5 - Add word 0010 01d0 kkkk kkkk
// RULE6 - Bit-set forces chosen bit, flags untouched
// RULE7 - Bit-set word 1000 bbb0 kkkk kkkk
// RULE8 - Set-all writes FFh, flags untouched
// RULE9 - Set-all word 0110 1000 kkkk kkkk
// RULE10 - Decode, read, process, write in four phases
// RULE11 - Extension fuse low disables indexed addressing
// RULE12 - Disabled: access bit picks access or banked
// RULE13 - Redirect only when enabled, access zero, low
// RULE14 - Effective address wraps to address width
`timescale 1ns/100ps
`default_nettype none
module ilod_top (
  // Clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_i,
  // Configuration
  input  wire logic                          extension_enable_fuse_i,
  // Instruction stream
  input  wire logic                          instr_valid_i,
  input  wire logic [ilod_pkg::INSTR_W-1:0]  instr_word_i,
  // Core registers
  input  wire logic [ilod_pkg::ADDR_W-1:0]   index_pointer_two_i,
  input  wire logic [ilod_pkg::BANK_W-1:0]   bank_select_reg_i,
  input  wire logic                          accum_load_i,
  input  wire logic [ilod_pkg::DATA_W-1:0]   accum_load_data_i,
  // Data memory
  output logic      [ilod_pkg::ADDR_W-1:0]   mem_addr_o,
  output logic                               mem_rd_o,
  input  wire logic [ilod_pkg::DATA_W-1:0]   mem_rdata_i,
  output logic                               mem_wr_o,
  output logic      [ilod_pkg::DATA_W-1:0]   mem_wdata_o,
  // Status and observation
  output logic      [ilod_pkg::DATA_W-1:0]   accum_o,
  output logic      [ilod_pkg::STATUS_W-1:0] status_o,
  output var ilod_pkg::ilod_phase_t          q_phase_o,
  output logic                               instr_taken_o,
  output logic                               instr_ignored_o,
  output logic                               indexed_o,
  output logic                               instr_done_o
);

  // ************************************************************
  // Declarations
  // ************************************************************
  ilod_pkg::ilod_phase_t               phase_ff;
  ilod_pkg::ilod_phase_t               nxt_phase;
  ilod_pkg::ilod_op_t                  op_ff;
  ilod_pkg::ilod_op_t                  dec_op;

  logic [ilod_pkg::INSTR_W-1:0]        ir_ff;
  logic [ilod_pkg::DATA_W-1:0]         result_ff;
  logic [ilod_pkg::STATUS_W-1:0]       flags_ff;
  logic                                flags_wr_ff;
  logic                                dest_file_ff;
  logic                                busy_ff;

  logic [ilod_pkg::DATA_W-1:0]         accum_ff;
  logic [ilod_pkg::STATUS_W-1:0]       status_ff;

  logic [ilod_pkg::ADDR_W-1:0]         mem_addr_ff;
  logic                                mem_rd_ff;
  logic                                mem_wr_ff;
  logic [ilod_pkg::DATA_W-1:0]         mem_wdata_ff;

  logic                                taken_ff;
  logic                                ignored_ff;
  logic                                indexed_ff;
  logic                                done_ff;

  logic                                is_add;
  logic                                is_bset;
  logic                                is_setall;

  logic                                at_q1;
  logic                                at_q2;
  logic                                at_q3;
  logic                                at_q4;
  logic                                take;

  logic [ilod_pkg::ADDR_W-1:0]         dec_addr;
  logic                                dec_indexed;
  logic [ilod_pkg::DATA_W-1:0]         alu_result;
  logic [ilod_pkg::STATUS_W-1:0]       alu_flags;
  logic                                alu_flags_wr;
  logic                                dec_dest_file;

  // Bank nibble over offset byte fills the address
  if (ilod_pkg::ADDR_W != ilod_pkg::BANK_W + ilod_pkg::DATA_W) begin : g_chk_addr
    $error("Address width mismatch");
  end
  if ((1 << ilod_pkg::BIT_W) != ilod_pkg::DATA_W) begin : g_chk_bit
    $error("Bit field width mismatch");
  end

  // ************************************************************
  // Quadrature phase sequencer
  // ************************************************************
  // Four clocks per instruction cycle
  always_comb begin
    case (phase_ff)
      ilod_pkg::ILOD_Q1: nxt_phase = ilod_pkg::ILOD_Q2;
      ilod_pkg::ILOD_Q2: nxt_phase = ilod_pkg::ILOD_Q3;
      ilod_pkg::ILOD_Q3: nxt_phase = ilod_pkg::ILOD_Q4;
      ilod_pkg::ILOD_Q4: nxt_phase = ilod_pkg::ILOD_Q1;
      default:           nxt_phase = ilod_pkg::ILOD_Q1;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff <= ilod_pkg::ILOD_Q1;
    end else begin
      phase_ff <= nxt_phase; // RULE10
    end
  end

  assign at_q1 = (phase_ff == ilod_pkg::ILOD_Q1);
  assign at_q2 = (phase_ff == ilod_pkg::ILOD_Q2);
  assign at_q3 = (phase_ff == ilod_pkg::ILOD_Q3);
  assign at_q4 = (phase_ff == ilod_pkg::ILOD_Q4);

  // ************************************************************
  // Decode
  // ************************************************************
  // Access bit is part of each standard word; indexed form needs it at zero
  assign is_add    = (instr_word_i[15:10] == ilod_pkg::ADD_OPCODE); // RULE5
  assign is_bset   = (instr_word_i[15:12] == ilod_pkg::BSET_OPCODE); // RULE7
  assign is_setall = (instr_word_i[15:9]  == ilod_pkg::SETALL_OPCODE); // RULE9

  assign dec_op = is_add    ? ilod_pkg::ILOD_OP_ADD :
                  is_bset   ? ilod_pkg::ILOD_OP_BSET :
                  is_setall ? ilod_pkg::ILOD_OP_SETALL :
                  ilod_pkg::ILOD_OP_NONE;

  // Only the add can target the accumulator
  assign dec_dest_file = ~is_add
                        | (instr_word_i[ilod_pkg::DEST_BIT] == ilod_pkg::DEST_FILE); // RULE3

  // A word is only looked at in the decode phase
  assign take = at_q1 & instr_valid_i & (dec_op != ilod_pkg::ILOD_OP_NONE); // RULE10

  ilod_addr_gen u_addr_gen (
    .ext_en_i   (extension_enable_fuse_i),
    .access_i   (instr_word_i[ilod_pkg::ACCESS_BIT]),
    .offset_i   (instr_word_i[ilod_pkg::OFFSET_MSB:0]),
    .idx_ptr_i  (index_pointer_two_i),
    .bank_i     (bank_select_reg_i),
    .eff_addr_o (dec_addr),
    .indexed_o  (dec_indexed)
  );

  // ************************************************************
  // Process
  // ************************************************************
  ilod_alu u_alu (
    .op_i       (op_ff),
    .bit_sel_i  (ir_ff[ilod_pkg::BITNUM_MSB:ilod_pkg::BITNUM_LSB]),
    .accum_i    (accum_ff),
    .opnd_i     (mem_rdata_i),
    .result_o   (alu_result),
    .flags_o    (alu_flags),
    .flags_wr_o (alu_flags_wr)
  );

  // ************************************************************
  // Decode phase captures
  // ************************************************************
  // Fields held until the next word
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ir_ff        <= ilod_pkg::INSTR_RST;
      op_ff        <= ilod_pkg::ILOD_OP_NONE;
      dest_file_ff <= ilod_pkg::DEST_FILE;
      mem_addr_ff  <= ilod_pkg::ADDR_RST;
      indexed_ff   <= 1'b0;
    end else if (take) begin
      ir_ff        <= instr_word_i; // RULE10
      op_ff        <= dec_op;
      dest_file_ff <= dec_dest_file; // RULE3
      mem_addr_ff  <= dec_addr; // RULE1 RULE12
      indexed_ff   <= dec_indexed; // RULE11
    end
  end

  // Busy from Q2 through Q4
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_ff    <= 1'b0;
      taken_ff   <= 1'b0;
      ignored_ff <= 1'b0;
    end else begin
      busy_ff    <= take | (busy_ff & ~at_q4);
      taken_ff   <= take;
      // Unsupported words pass as a no-op cycle
      ignored_ff <= at_q1 & instr_valid_i & ~take;
    end
  end

  // ************************************************************
  // Operand read
  // ************************************************************
  // Strobe spans the read phase only
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_rd_ff <= 1'b0;
    end else begin
      mem_rd_ff <= take; // RULE10
    end
  end

  // ************************************************************
  // Process phase result capture
  // ************************************************************
  // Read data used directly, no holding flop
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      result_ff   <= ilod_pkg::ACCUM_RST;
      flags_ff    <= ilod_pkg::STATUS_RST;
      flags_wr_ff <= 1'b0;
    end else if (busy_ff & at_q3) begin
      result_ff   <= alu_result; // RULE2 RULE6 RULE8
      flags_ff    <= alu_flags; // RULE4
      flags_wr_ff <= alu_flags_wr;
    end
  end

  // ************************************************************
  // Destination write
  // ************************************************************
  // Memory write strobe stands through the write phase
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_wr_ff    <= 1'b0;
      mem_wdata_ff <= ilod_pkg::ACCUM_RST;
    end else if (busy_ff & at_q3) begin
      mem_wr_ff    <= dest_file_ff; // RULE3 RULE10
      mem_wdata_ff <= alu_result;
    end else begin
      mem_wr_ff    <= 1'b0;
    end
  end

  // Commit at the end of the write phase; instruction result beats a load
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      accum_ff <= ilod_pkg::ACCUM_RST;
    end else if (busy_ff & at_q4 & ~dest_file_ff) begin
      accum_ff <= result_ff; // RULE3
    end else if (accum_load_i) begin
      accum_ff <= accum_load_data_i;
    end
  end

  // Only the add commits flags
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      status_ff <= ilod_pkg::STATUS_RST;
    end else if (busy_ff & at_q4 & flags_wr_ff) begin
      status_ff <= flags_ff; // RULE4
    end
  end

  // Done lands in the next Q1
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= busy_ff & at_q4; // RULE10
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // All outputs come from flops
  assign mem_addr_o      = mem_addr_ff;
  assign mem_rd_o        = mem_rd_ff;
  assign mem_wr_o        = mem_wr_ff;
  assign mem_wdata_o     = mem_wdata_ff;

  assign accum_o         = accum_ff;
  assign status_o        = status_ff;

  assign q_phase_o       = phase_ff;
  assign instr_taken_o   = taken_ff;
  assign instr_ignored_o = ignored_ff;
  assign indexed_o       = indexed_ff;
  assign instr_done_o    = done_ff;

endmodule // ilod_top
`default_nettype wire

/* File: verif/ilod_top_monitor.sv */
// Purpose: Port-level checks on the indexed offset decoder
// Assumes: One clock, asynchronous active-high reset
// Notes:   Bound at the foot of this file
`timescale 1ns/100ps
`default_nettype none
module ilod_top_monitor (
  // Clock and reset
  input wire logic                          ref_clk_i,
  input wire logic                          rst_i,
  // Inputs
  input wire logic                          extension_enable_fuse_i,
  input wire logic                          instr_valid_i,
  input wire logic [ilod_pkg::INSTR_W-1:0]  instr_word_i,
  input wire logic [ilod_pkg::ADDR_W-1:0]   index_pointer_two_i,
  input wire logic [ilod_pkg::BANK_W-1:0]   bank_select_reg_i,
  // Outputs
  input wire logic [ilod_pkg::ADDR_W-1:0]   mem_addr_o,
  input wire logic                          mem_rd_o,
  input wire logic                          mem_wr_o,
  input wire logic [ilod_pkg::DATA_W-1:0]   mem_wdata_o,
  input wire logic [ilod_pkg::STATUS_W-1:0] status_o,
  input wire ilod_pkg::ilod_phase_t         q_phase_o,
  input wire logic                          instr_taken_o,
  input wire logic                          indexed_o,
  input wire logic                          instr_done_o
);
  // ************************************************************
  // Decode helpers
  // ************************************************************
  logic is_add;
  logic is_bset;
  logic is_set;
  logic is_op;
  logic fz;
  assign fz      = !instr_word_i[8] && extension_enable_fuse_i;
  assign is_add  = instr_valid_i && q_phase_o == ilod_pkg::ILOD_Q1
                   && instr_word_i[15:10] == ilod_pkg::ADD_OPCODE;
  assign is_bset = instr_valid_i && q_phase_o == ilod_pkg::ILOD_Q1
                   && instr_word_i[15:12] == ilod_pkg::BSET_OPCODE;
  assign is_set  = instr_valid_i && q_phase_o == ilod_pkg::ILOD_Q1
                   && instr_word_i[15:9] == ilod_pkg::SETALL_OPCODE;
  assign is_op   = is_add || is_bset || is_set;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // ************************************************************
  // Assertions
  // ************************************************************
  a_phase_steps: assert property (!rst_i |=> q_phase_o == $past(q_phase_o) + 2'h1)
    else $error("phase did not advance");
  a_read_after_take: assert property (is_op |=> mem_rd_o && instr_taken_o)
    else $error("no read after taken word");
  a_done_in_four: assert property (instr_taken_o |-> ##3 (instr_done_o
    && q_phase_o == 2'h0))
    else $error("done not four phases on");
  a_write_phase: assert property (mem_wr_o |-> q_phase_o == ilod_pkg::ILOD_Q4)
    else $error("write outside last phase");
  a_idx_address: assert property (is_op && fz && instr_word_i[7:0] <= 8'h5F
    |=> indexed_o && mem_addr_o == $past(index_pointer_two_i) + $past(instr_word_i[7:0]))
    else $error("indexed address wrong");
  a_fuse_off_literal: assert property (is_op && !extension_enable_fuse_i
    && !instr_word_i[8] |=> !indexed_o && mem_addr_o[7:0] == $past(instr_word_i[7:0])
    && mem_addr_o[11:8] == ($past(instr_word_i[7:0]) > 8'h5F ? 4'hF : 4'h0))
    else $error("literal access address wrong");
  a_bank_select: assert property (is_op && instr_word_i[8] |=> !indexed_o
    && mem_addr_o == {$past(bank_select_reg_i), $past(instr_word_i[7:0])})
    else $error("banked address wrong");
  a_high_offset: assert property (is_op && fz && instr_word_i[7:0] > 8'h5F
    |=> !indexed_o && mem_addr_o == {4'hF, $past(instr_word_i[7:0])})
    else $error("high access address wrong");
  a_setall_ones: assert property (is_set |-> ##3 mem_wr_o && mem_wdata_o == 8'hFF)
    else $error("set-all write wrong");
  a_flags_kept: assert property (is_bset || is_set |-> ##4 $stable(status_o))
    else $error("flags changed");
  a_add_dest: assert property (is_add |-> ##3 mem_wr_o == $past(instr_word_i[9], 3))
    else $error("add destination wrong");
  a_bset_write: assert property (is_bset |-> ##3 mem_wr_o)
    else $error("bit-set did not write");

  c_add: cover property (is_add && fz);
  c_bset: cover property (is_bset);
  c_set: cover property (is_set && instr_word_i[8]);
endmodule // ilod_top_monitor

bind ilod_top ilod_top_monitor u_ilod_top_monitor (
  .ref_clk_i(ref_clk_i), .rst_i(rst_i), .extension_enable_fuse_i(extension_enable_fuse_i),
  .instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i),
  .index_pointer_two_i(index_pointer_two_i), .bank_select_reg_i(bank_select_reg_i),
  .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
  .mem_wdata_o(mem_wdata_o), .status_o(status_o), .q_phase_o(q_phase_o),
  .instr_taken_o(instr_taken_o), .indexed_o(indexed_o), .instr_done_o(instr_done_o));
`default_nettype wire

/* File: verif/tb_top.sv */
// Purpose: Directed bench for the indexed offset decoder
// Assumes: Memory answers in the phase after the read strobe
// Notes:   Each word is issued from a Q4 negedge so it sits on the Q1 edge
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic                          ref_clk_i;
  logic                          rst_i;
  logic                          fuse;
  logic                          valid;
  logic [ilod_pkg::INSTR_W-1:0]  word;
  logic [ilod_pkg::ADDR_W-1:0]   ptr;
  logic [ilod_pkg::BANK_W-1:0]   bank_select_reg;
  logic                          acc_ld;
  logic [ilod_pkg::DATA_W-1:0]   acc_d;
  logic [ilod_pkg::DATA_W-1:0]   rdata;
  logic [ilod_pkg::ADDR_W-1:0]   mem_addr_o;
  logic                          mem_rd_o;
  logic                          mem_wr_o;
  logic [ilod_pkg::DATA_W-1:0]   mem_wdata_o;
  logic [ilod_pkg::DATA_W-1:0]   accum_o;
  logic [ilod_pkg::STATUS_W-1:0] status_o;
  ilod_pkg::ilod_phase_t         q_phase_o;
  logic                          instr_taken_o;
  logic                          instr_ignored_o;
  logic                          indexed_o;
  logic                          instr_done_o;
  logic [7:0]                    exp_acc;
  logic [4:0]                    exp_st;
  int                            mismatches;
  int                            n_compared;

  ilod_top u_ilod_top (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .extension_enable_fuse_i(fuse),
    .instr_valid_i(valid), .instr_word_i(word), .index_pointer_two_i(ptr),
    .bank_select_reg_i(bank_select_reg), .accum_load_i(acc_ld), .accum_load_data_i(acc_d),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_rdata_i(rdata),
    .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .accum_o(accum_o),
    .status_o(status_o), .q_phase_o(q_phase_o), .instr_taken_o(instr_taken_o),
    .instr_ignored_o(instr_ignored_o), .indexed_o(indexed_o),
    .instr_done_o(instr_done_o));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Bounded wait for a Q4 negedge so the next edge opens Q1
  task automatic to_q4();
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_i);
      if (q_phase_o === ilod_pkg::ILOD_Q4) return;
    end
    mismatches++;
    wrap_up();
  endtask

  task automatic load_acc(input logic [7:0] d);
    @(posedge ref_clk_i);
    acc_ld <= 1'b1;
    acc_d  <= d;
    @(posedge ref_clk_i);
    acc_ld <= 1'b0;
    exp_acc = d;
  endtask

  function automatic logic [4:0] add_st(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    logic [4:0] f;
    s = {1'b0, a} + {1'b0, b};
    f[ilod_pkg::FLAG_C]  = s[8];
    f[ilod_pkg::FLAG_DC] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
    f[ilod_pkg::FLAG_Z]  = s[7:0] == 8'h00;
    f[ilod_pkg::FLAG_OV] = (a[7] == b[7]) && (s[7] != a[7]);
    f[ilod_pkg::FLAG_N]  = s[7];
    return f;
  endfunction

  // One full instruction cycle with memory answer and all visible effects
  task automatic run_op(input logic f, input logic [15:0] w, input logic [11:0] p,
                        input logic [7:0] rd, input logic [11:0] ea, input logic ix,
                        input logic wr, input logic [7:0] wd);
    to_q4();
    @(posedge ref_clk_i);
    fuse  <= f;
    valid <= 1'b1;
    word  <= w;
    ptr   <= p;
    @(posedge ref_clk_i);
    valid <= 1'b0;
    ptr   <= ~p;
    @(negedge ref_clk_i);
    check({mem_rd_o, instr_taken_o}, 16'h0003);
    check(mem_addr_o, ea);
    check(indexed_o, ix);
    @(posedge ref_clk_i);
    rdata <= rd;
    @(posedge ref_clk_i);
    rdata <= ~rd;
    @(negedge ref_clk_i);
    check(mem_wr_o, wr);
    if (wr) check(mem_wdata_o, wd);
    @(negedge ref_clk_i);
    check(instr_done_o, 16'h0001);
    check(accum_o, exp_acc);
    check(status_o, exp_st);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_add();
    load_acc(8'h17);
    exp_st  = add_st(8'h17, 8'h20);
    exp_acc = 8'h37;
    run_op(1'b1, 16'h242C, 12'hA00, 8'h20, 12'hA2C, 1'b1, 1'b0, 8'h00);
    load_acc(8'h80);
    exp_st = add_st(8'h80, 8'h80);
    run_op(1'b1, 16'h265F, 12'hFF0, 8'h80, 12'h04F, 1'b1, 1'b1, 8'h00);
  endtask

  task automatic t_bset();
    for (int b = 0; b < 8; b++) begin
      run_op(1'b1, {4'h8, 3'(b), 1'b0, 8'h0A}, 12'h100, 8'h55, 12'h10A, 1'b1, 1'b1,
             8'h55 | (8'h01 << b));
    end
  endtask

  task automatic t_setall();
    run_op(1'b1, 16'h682C, 12'hA00, 8'h00, 12'hA2C, 1'b1, 1'b1, 8'hFF);
    run_op(1'b1, 16'h6860, 12'hA00, 8'h00, 12'hF60, 1'b0, 1'b1, 8'hFF);
    run_op(1'b0, 16'h682C, 12'hA00, 8'h00, 12'h02C, 1'b0, 1'b1, 8'hFF);
    @(posedge ref_clk_i);
    bank_select_reg <= 4'h3;
    run_op(1'b0, 16'h692C, 12'hA00, 8'h00, 12'h32C, 1'b0, 1'b1, 8'hFF);
    @(posedge ref_clk_i);
    bank_select_reg <= 4'h5;
    run_op(1'b1, 16'h692C, 12'hA00, 8'h00, 12'h52C, 1'b0, 1'b1, 8'hFF);
  endtask

  // Unknown word: pulse only, no memory cycle
  task automatic t_ignored();
    to_q4();
    @(posedge ref_clk_i);
    valid <= 1'b1;
    word  <= 16'h0000;
    @(posedge ref_clk_i);
    valid <= 1'b0;
    @(negedge ref_clk_i);
    check({instr_ignored_o, instr_taken_o, mem_rd_o}, 16'h0004);
  endtask

  initial begin
    rst_i = 1'b1;
    fuse = 1'b1;
    valid = 1'b0;
    word = 16'h0000;
    ptr = 12'h000;
    bank_select_reg = 4'h0;
    acc_ld = 1'b0;
    acc_d = 8'h00;
    rdata = 8'h00;
    mismatches = 0;
    n_compared = 0;
    exp_acc = 8'h00;
    exp_st = 5'h00;
    repeat (16) @(posedge ref_clk_i);
    check({accum_o, 3'h0, status_o}, 16'h0000);
    rst_i <= 1'b0;
    t_add();
    t_bset();
    t_setall();
    t_ignored();
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
